// ==== logic/acf_channel_filter_control.sv ====
// voltage/temperature channel and shared filter configuration with output rate timing
// Function
// - enable bit powers channel up or down
// - excitation field selects 50 uA sources
// - coding bit: one unipolar, zero twos complement
// - input select: battery, external, internal, short
// - reference bit: internal or half supply
// - modifying filter write resets both converters
// - chop: rate divided three when averaging zero
// - running average forced on during chop
// - six-bit averaging factor sets post-filter
// - modify bit adds second notch
// - rate is 512000 over (factor+1) times 64
// - factors 126, 127 force 60, 50 Hz
// - averaging divides rate by three plus factor
// - first result waits extra 60 us
// - slowest output rate held at 10 Hz
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module acf_channel_filter_control #(
  parameter int STARTUP_CYCLES = acf_pkg::ACF_STARTUP_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire acf_pkg::acf_avl_req_t avlReq,
  output logic [31:0] avlReaddata,
  output logic avlWaitrequest,
  // analog and filter settings
  output acf_pkg::acf_vt_cfg_t vtCfg,
  output acf_pkg::acf_flt_cfg_t fltCfg,
  // converter control and timing
  output logic convReset,
  output logic vtSampleStrobe,
  output logic vtSettled
);
  import acf_pkg::*;

  // sequencer states of the channel timing
  typedef enum logic [1:0] {ST_OFF, ST_START, ST_SETTLE, ST_RUN} acf_state_t;

  // output period in modulator ticks, with the rate floor applied
  function automatic logic [19:0] periodTicks(input logic [6:0] sf, input logic [5:0] af,
                                              input logic chop);
    logic [13:0] base;
    logic [6:0] mult;
    logic [20:0] prod;
    base = 14'((32'(sf) + 1) * ACF_SF_OSR);
    mult = 7'h01;
    if (sf == 7'h7E) begin
      base = 14'(ACF_TICKS_60);
    end else if (sf == 7'h7F) begin
      base = 14'(ACF_TICKS_50);
    end
    if (af != 6'h00) begin
      mult = 7'(32'(af) + ACF_AF_OFFSET);
    end else if (chop) begin
      // chop without averaging: plain factor of three, no extra term
      mult = 7'(ACF_CHOP_DIV);
    end
    prod = 21'(base) * 21'(mult);
    if (prod > 21'(ACF_TICKS_MAX)) begin
      prod = 21'(ACF_TICKS_MAX);
    end
    periodTicks = prod[19:0];
  endfunction : periodTicks

  // settling length in output periods
  function automatic logic [2:0] settlePeriods(input logic [5:0] af, input logic chop,
                                               input logic ravg);
    if (chop) begin
      settlePeriods = 3'(ACF_SETTLE_CHOP);
    end else if (af != 6'h00) begin
      settlePeriods = 3'(ACF_SETTLE_AVG + 32'(ravg));
    end else begin
      settlePeriods = 3'(ACF_SETTLE_PLAIN + 32'(ravg));
    end
  endfunction : settlePeriods

  // register storage
  logic [15:0] vtCtrl; // channel control word
  logic [15:0] fltWord; // filter configuration word
  logic vtEnPrev; // enable of the last cycle, for the rising edge
  logic [7:0] sampleCount; // results produced since start

  // timing state
  acf_state_t state;
  acf_state_t next_state;
  logic [28:0] phaseAcc; // fractional divider toward the modulator rate
  logic modTick; // one-cycle modulator enable
  logic [19:0] tickCount; // ticks within the current output period
  logic [15:0] startCount; // start-up delay counter
  logic [2:0] periodCount; // settling periods done

  // bus decode
  wire busReq = avlReq.read | avlReq.write;
  wire accept = busReq & avlWaitrequest; // first cycle of a request
  wire hitVt = avlReq.address == ACF_VT_CTRL_ADDR;
  wire hitFlt = avlReq.address == ACF_FLT_CFG_ADDR;
  wire hitStat = avlReq.address == ACF_STATUS_ADDR;
  wire commit = avlReq.write & ~avlWaitrequest; // write takes effect here
  wire [15:0] byteMask = {{8{avlReq.byteenable[1]}}, {8{avlReq.byteenable[0]}}};
  wire [15:0] vtMerged = (vtCtrl & ~byteMask) | (avlReq.writedata[15:0] & byteMask);
  wire [15:0] fltMerged = (fltWord & ~byteMask) | (avlReq.writedata[15:0] & byteMask);
  wire fltChanged = commit & hitFlt & (fltMerged != fltWord);
  wire vtWrite = commit & hitVt;

  // status word: settled, busy and sample count
  wire busy = (state == ST_START) | (state == ST_SETTLE);
  wire [15:0] statusWord = {sampleCount, 6'h00, busy, vtSettled};
  wire [15:0] readMux = hitVt ? vtCtrl :
                        hitFlt ? fltWord :
                        hitStat ? statusWord : 16'h0000; // unmapped reads zero

  // decoded filter fields
  wire chopOn = fltWord[ACF_FLT_CHOP_BIT];
  wire [5:0] afVal = fltWord[ACF_FLT_AF_LSB +: 6];
  wire [6:0] sfVal = fltWord[ACF_FLT_SF_LSB +: 7];
  wire ravgEff = fltWord[ACF_FLT_RAVG_BIT] | chopOn;
  wire [19:0] periodLen = periodTicks(sfVal, afVal, chopOn);
  wire [2:0] settleLen = settlePeriods(afVal, chopOn, ravgEff);
  wire vtOn = vtCtrl[ACF_VT_EN_BIT];
  wire restart = fltChanged | (vtOn & ~vtEnPrev);
  wire periodEnd = modTick & (tickCount >= periodLen - 20'h00001);
  wire [28:0] phaseSum = phaseAcc + 29'(ACF_MOD_HZ);

  // avalon handshake: one wait cycle, then a single low cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      avlWaitrequest <= 1'b1;
      avlReaddata <= 32'h00000000;
    end else begin
      avlWaitrequest <= ~accept;
      if (accept) begin
        avlReaddata <= {16'h0000, readMux};
      end
    end
  end

  // channel control register; reserved bits are stored as written
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      vtCtrl <= ACF_VT_CTRL_RST;
    end else if (vtWrite) begin
      vtCtrl <= vtMerged;
    end
  end

  // filter register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fltWord <= ACF_FLT_CFG_RST;
    end else if (commit & hitFlt) begin
      fltWord <= fltMerged;
    end
  end

  // converter reset pulse after a modifying filter write
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      convReset <= 1'b0;
    end else begin
      convReset <= fltChanged;
    end
  end

  // analog settings leave through flops so they never glitch
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      vtCfg <= '0;
    end else begin
      vtCfg.enable <= vtOn;
      vtCfg.srcExtTemp <= vtCtrl[ACF_VT_EXC_LSB];
      vtCfg.srcSwGround <= vtCtrl[ACF_VT_EXC_LSB + 1];
      vtCfg.unipolar <= vtCtrl[ACF_VT_CODE_BIT];
      vtCfg.inputSel <= vtCtrl[ACF_VT_SEL_LSB +: 2];
      vtCfg.refHalfSupply <= vtCtrl[ACF_VT_REF_BIT];
    end
  end

  // filter settings to the decimator
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fltCfg <= '0;
    end else begin
      fltCfg.chop <= chopOn;
      fltCfg.runAverage <= ravgEff;
      fltCfg.avgFactor <= afVal;
      fltCfg.secondNotch <= fltWord[ACF_FLT_NOTCH_BIT];
      fltCfg.decimation <= sfVal;
    end
  end

  // fractional divider: 200 MHz is no whole multiple of the modulator rate,
  // so the tick jitters by one cycle while the mean rate stays exact
  // the divider is held at zero during start-up so that settling spans whole
  // output periods; a free-running phase would cut the first period short
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      phaseAcc <= 29'h00000000;
      modTick <= 1'b0;
    end else if (state == ST_START) begin
      phaseAcc <= 29'h00000000;
      modTick <= 1'b0;
    end else if (phaseSum >= 29'(ACF_CLK_HZ)) begin
      phaseAcc <= phaseSum - 29'(ACF_CLK_HZ);
      modTick <= 1'b1;
    end else begin
      phaseAcc <= phaseSum;
      modTick <= 1'b0;
    end
  end

  // next state of the channel sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (vtOn) begin
          next_state = ST_START;
        end
      end
      ST_START: begin
        if (startCount >= 16'(STARTUP_CYCLES - 1)) begin
          next_state = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (periodEnd & (periodCount >= settleLen - 3'h1)) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
    if (!vtOn) begin
      next_state = ST_OFF;
    end else if (restart) begin
      next_state = ST_START;
    end
  end

  // sequencer registers; a restart clears all counts, except startCount when it comes while already in ST_START
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= ST_OFF;
      vtEnPrev <= 1'b0;
    end else begin
      state <= next_state;
      vtEnPrev <= vtOn;
    end
  end

  // start-up delay and period counters
  always_ff @(posedge clk_sys) begin
    if (sys_rst || next_state != state || state == ST_OFF) begin
      startCount <= 16'h0000;
      tickCount <= 20'h00000;
      periodCount <= 3'h0;
    end else begin
      if (state == ST_START) begin
        startCount <= startCount + 16'h0001;
      end
      if (periodEnd) begin
        tickCount <= 20'h00000;
        if (state == ST_SETTLE) begin
          periodCount <= periodCount + 3'h1;
        end
      end else if (modTick && state != ST_START) begin
        tickCount <= tickCount + 20'h00001;
      end
    end
  end

  // result strobe once settled, and settled flag
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      vtSampleStrobe <= 1'b0;
      vtSettled <= 1'b0;
      sampleCount <= 8'h00;
    end else begin
      vtSampleStrobe <= (state == ST_RUN) & periodEnd & vtOn & ~restart;
      vtSettled <= next_state == ST_RUN;
      if (restart || !vtOn) begin
        sampleCount <= 8'h00;
      end else if (state == ST_RUN && periodEnd) begin
        sampleCount <= sampleCount + 8'h01; // wraps, a coarse activity sign only
      end
    end
  end
endmodule : acf_channel_filter_control
`default_nettype wire

// ==== logic/acf_pkg.sv ====
// shared constants and carrier types for the converter channel and filter control
package acf_pkg;
  // register byte addresses
  localparam logic [31:0] ACF_VT_CTRL_ADDR = 32'hFFFF0510;
  localparam logic [31:0] ACF_FLT_CFG_ADDR = 32'hFFFF0518;
  localparam logic [31:0] ACF_STATUS_ADDR = 32'hFFFF05F0;
  // reset values
  localparam logic [15:0] ACF_VT_CTRL_RST = 16'h0000;
  localparam logic [15:0] ACF_FLT_CFG_RST = 16'h0007;
  // field positions, control register
  localparam int ACF_VT_EN_BIT = 15;
  localparam int ACF_VT_EXC_LSB = 13;
  localparam int ACF_VT_CODE_BIT = 9;
  localparam int ACF_VT_SEL_LSB = 6;
  localparam int ACF_VT_REF_BIT = 4;
  // field positions, filter register
  localparam int ACF_FLT_CHOP_BIT = 15;
  localparam int ACF_FLT_RAVG_BIT = 14;
  localparam int ACF_FLT_AF_LSB = 8;
  localparam int ACF_FLT_NOTCH_BIT = 7;
  localparam int ACF_FLT_SF_LSB = 0;
  // timing: system clock, modulator rate, rate table
  localparam int ACF_CLK_HZ = 200_000_000;
  localparam int ACF_MOD_HZ = 512_000;
  localparam int ACF_SF_OSR = 64;
  localparam int ACF_SF_MAX_FORMULA = 125;
  localparam int ACF_RATE_60_HZ = 60;
  localparam int ACF_RATE_50_HZ = 50;
  localparam int ACF_RATE_MIN_HZ = 10;
  localparam int ACF_AF_OFFSET = 3;
  localparam int ACF_CHOP_DIV = 3;
  localparam int ACF_TICKS_60 = ACF_MOD_HZ / ACF_RATE_60_HZ;
  localparam int ACF_TICKS_50 = ACF_MOD_HZ / ACF_RATE_50_HZ;
  localparam int ACF_TICKS_MAX = ACF_MOD_HZ / ACF_RATE_MIN_HZ;
  // settling in output periods
  localparam int ACF_SETTLE_CHOP = 2;
  localparam int ACF_SETTLE_PLAIN = 3;
  localparam int ACF_SETTLE_AVG = 1;
  // start-up delay per converter
  localparam int ACF_STARTUP_NS = 60_000;
  localparam int ACF_STARTUP_CYC = (ACF_STARTUP_NS * (ACF_CLK_HZ / 1_000_000) + 999) / 1000;
  // avalon request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [31:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } acf_avl_req_t;
  // analog front-end settings of the voltage/temperature channel
  typedef struct packed {
    logic enable;
    logic srcExtTemp;
    logic srcSwGround;
    logic unipolar;
    logic [1:0] inputSel;
    logic refHalfSupply;
  } acf_vt_cfg_t;
  // decimation filter settings shared by both converters
  typedef struct packed {
    logic chop;
    logic runAverage;
    logic [5:0] avgFactor;
    logic secondNotch;
    logic [6:0] decimation;
  } acf_flt_cfg_t;
endpackage : acf_pkg

// ==== verification/acf_props.sv ====
// assertion checker for the channel and filter control block
`timescale 1ns/1ps
`default_nettype none
module acf_props #(
  parameter int STARTUP_CYCLES = 20
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register bus
  input wire acf_pkg::acf_avl_req_t avlReq,
  input wire logic [31:0] avlReaddata,
  input wire logic avlWaitrequest,
  // settings and timing
  input wire acf_pkg::acf_vt_cfg_t vtCfg,
  input wire acf_pkg::acf_flt_cfg_t fltCfg,
  input wire logic convReset,
  input wire logic vtSampleStrobe,
  input wire logic vtSettled
);
  import acf_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // accepted full-width writes per register
  wire done = avlReq.write && !avlWaitrequest && avlReq.byteenable[1:0] == 2'h3;
  wire accV = done && avlReq.address == ACF_VT_CTRL_ADDR;
  wire accF = done && avlReq.address == ACF_FLT_CFG_ADDR;
  // any committed filter write, whatever its lanes
  wire wrF = avlReq.write && !avlWaitrequest && avlReq.address == ACF_FLT_CFG_ADDR;
  logic [15:0] wd1; // write data one cycle back
  logic [15:0] wd2; // two cycles back, lines up with the struct outputs
  logic [31:0] upCnt; // cycles since the channel was last started
  // delay line and start-up counter; restart clears the count
  always_ff @(posedge clk_sys) begin
    wd1 <= avlReq.writedata[15:0];
    wd2 <= wd1;
    upCnt <= (sys_rst || !vtCfg.enable || convReset) ? 32'h0 : upCnt + 32'h1;
  end
  chk_vt_enable: assert property (accV |-> ##2 vtCfg.enable == wd2[15])
    else $error("enable bit not applied");
  chk_exc_src: assert property (accV |-> ##2 {vtCfg.srcSwGround, vtCfg.srcExtTemp} == wd2[14:13])
    else $error("excitation field not applied");
  chk_code_bit: assert property (accV |-> ##2 vtCfg.unipolar == wd2[9])
    else $error("coding bit not applied");
  chk_input_sel: assert property (accV |-> ##2 vtCfg.inputSel == wd2[7:6])
    else $error("input select not applied");
  chk_ref_sel: assert property (accV |-> ##2 vtCfg.refHalfSupply == wd2[4])
    else $error("reference select not applied");
  chk_filter_reset: assert property (convReset |-> $past(wrF, 1))
    else $error("converter reset without filter write");
  chk_chop_avg: assert property (fltCfg.chop |-> fltCfg.runAverage)
    else $error("running average off while chopping");
  chk_filter_fields: assert property (accF |-> ##2 fltCfg[13:0] == wd2[13:0] && fltCfg.chop == wd2[15])
    else $error("filter fields not applied");
  chk_startup_gap: assert property (vtSettled |-> upCnt > STARTUP_CYCLES)
    else $error("settled before start-up delay");
  chk_strobe_run: assert property (vtSampleStrobe |-> vtSettled)
    else $error("sample strobe while not settled");
  cover property ($rose(vtSettled));
  cover property (convReset);
  cover property (accV ##2 vtCfg.enable);
endmodule : acf_props
bind acf_channel_filter_control acf_props #(.STARTUP_CYCLES(STARTUP_CYCLES)) i_acf_props (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .avlReq(avlReq), .avlReaddata(avlReaddata),
  .avlWaitrequest(avlWaitrequest), .vtCfg(vtCfg), .fltCfg(fltCfg), .convReset(convReset),
  .vtSampleStrobe(vtSampleStrobe), .vtSettled(vtSettled));
`default_nettype wire

// ==== verification/acf_testbench.sv ====
// self-checking bench for the channel and filter control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import acf_pkg::*;
  localparam int SU = 20; // shortened start-up delay
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  acf_avl_req_t req = '0;
  logic [31:0] avlReaddata;
  logic avlWaitrequest;
  acf_vt_cfg_t vtCfg;
  acf_flt_cfg_t fltCfg;
  logic convReset;
  logic vtSampleStrobe;
  logic vtSettled;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int rstSeen = 0; // converter reset pulses seen
  int strobes = 0; // result strobes seen
  int r0;
  int n;
  int lo;
  logic [31:0] seed = 32'h00010BC1;
  logic [15:0] q;
  logic [15:0] d;
  logic [15:0] prev;
  logic [15:0] vtc [4] = '{16'hA250, 16'hC080, 16'hE2D0, 16'h0000};
  logic [15:0] fc [4] = '{16'h8000, 16'h8000, 16'h3F9F, 16'h007F};
  always #2.5 clk_sys = ~clk_sys;
  acf_channel_filter_control #(.STARTUP_CYCLES(SU)) i_acf_channel_filter_control (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .avlReq(req), .avlReaddata(avlReaddata),
    .avlWaitrequest(avlWaitrequest), .vtCfg(vtCfg), .fltCfg(fltCfg), .convReset(convReset),
    .vtSampleStrobe(vtSampleStrobe), .vtSettled(vtSettled));
  // cycle count, reset pulse count, hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (convReset === 1'b1) rstSeen <= rstSeen + 1;
    if (vtSampleStrobe === 1'b1) strobes <= strobes + 1;
    if (cyc == 80000) begin
      fail_count++;
      end_sim();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [15:0] expVt(input logic [15:0] v);
    return {9'h000, v[15], v[13], v[14], v[9], v[7:6], v[4]};
  endfunction : expVt
  function automatic logic [15:0] expFlt(input logic [15:0] v);
    return {v[15], v[14] | v[15], v[13:0]}; // chop forces running average
  endfunction : expFlt
  // software keeps to the permitted decimation and averaging pairs
  function automatic logic [15:0] legalFlt(input logic [15:0] v);
    logic [15:0] r;
    r = v;
    if (v[6]) r[13:8] = 6'h00;
    else if (v[5]) r[13:11] = 3'h0;
    return r;
  endfunction : legalFlt
  task automatic end_sim();
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one bus cycle; holds everything until waitrequest is sampled low
  task automatic bus(input logic w, input logic [31:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    req.read <= !w;
    req.write <= w;
    req.address <= a;
    req.writedata <= {16'h0000, v};
    req.byteenable <= 4'hF;
    do begin
      @(posedge clk_sys);
    end while (avlWaitrequest !== 1'b0);
    q = avlReaddata[15:0];
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask : bus
  // write, let the outputs settle, read back
  task automatic wreg(input logic [31:0] a, input logic [15:0] v);
    bus(1'b1, a, v);
    repeat (3) @(posedge clk_sys);
    bus(1'b0, a, 16'h0000);
  endtask : wreg
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    bus(1'b0, ACF_VT_CTRL_ADDR, 16'h0000);
    chk(q, 16'h0000);
    bus(1'b0, ACF_FLT_CFG_ADDR, 16'h0000);
    chk(q, 16'h0007);
    chk(fltCfg, 16'h0007);
    wreg(32'hFFFF0514, 16'hFFFF);
    chk(q, 16'h0000);
    chk({9'h000, vtCfg}, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      d = (i < 4) ? vtc[i] : (seed[15:0] & 16'hE2DF);
      wreg(ACF_VT_CTRL_ADDR, d);
      chk(q, d);
      chk({9'h000, vtCfg}, expVt(d));
    end
    prev = 16'h0007;
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      d = (i < 4) ? fc[i] : legalFlt(seed[15:0]);
      r0 = rstSeen;
      wreg(ACF_FLT_CFG_ADDR, d);
      chk(q, d);
      chk(fltCfg, expFlt(d));
      chk(16'(rstSeen - r0), {15'h0000, d != prev});
      prev = d;
    end
    // plain filter, three periods of settling after start-up
    wreg(ACF_FLT_CFG_ADDR, 16'h0000);
    wreg(ACF_VT_CTRL_ADDR, 16'h0000);
    bus(1'b1, ACF_VT_CTRL_ADDR, 16'h8000);
    lo = SU + ACF_SETTLE_PLAIN * (ACF_SF_OSR * (ACF_CLK_HZ / 1000) / (ACF_MOD_HZ / 1000));
    n = 0;
    while (vtSettled !== 1'b1 && n < lo + 500) begin
      @(posedge clk_sys);
      n++;
    end
    chk({15'h0000, n >= lo && n <= lo + 400}, 16'h0001);
    chk(16'(strobes), 16'h0000);
    bus(1'b0, ACF_STATUS_ADDR, 16'h0000);
    chk(q, 16'h0001);
    bus(1'b1, ACF_VT_CTRL_ADDR, 16'h0000);
    repeat (3) @(posedge clk_sys);
    chk({15'h0000, vtSettled}, 16'h0000);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
